// ---- rtl/pegr_defs.vh ----
// constants for the suspend/resume command gate of the serial flash
// assumes the serial decoder and the gate share one 20 MHz clock
`ifndef PEGR_DEFS_VH
`define PEGR_DEFS_VH

`define PEGR_CLK_MHZ 20
`define PEGR_OP_SUSPEND 8'hB0
`define PEGR_OP_RESUME 8'hD0

// latencies in ns; values are plain defaults, counts round up
`define PEGR_SUSPEND_LATENCY_NS 1000
`define PEGR_RESUME_LATENCY_NS 2000
`define PEGR_SUSPEND_CYC ((`PEGR_SUSPEND_LATENCY_NS * `PEGR_CLK_MHZ + 999) / 1000)
`define PEGR_RESUME_CYC ((`PEGR_RESUME_LATENCY_NS * `PEGR_CLK_MHZ + 999) / 1000)
`define PEGR_CNT_W 12

// command classes handed over by the command decoder
`define PEGR_CLS_W 6
`define PEGR_C_READ_ARRAY 6'h00
`define PEGR_C_READ_BUF1 6'h01
`define PEGR_C_READ_BUF2 6'h02
`define PEGR_C_BUF1_WRITE 6'h03
`define PEGR_C_BUF2_WRITE 6'h04
`define PEGR_C_B1_PGM_ERASE 6'h05
`define PEGR_C_B2_PGM_ERASE 6'h06
`define PEGR_C_B1_PGM_NOERASE 6'h07
`define PEGR_C_B2_PGM_NOERASE 6'h08
`define PEGR_C_MP_B1_ERASE 6'h09
`define PEGR_C_MP_B2_ERASE 6'h0A
`define PEGR_C_MP_B1_NOERASE 6'h0B
`define PEGR_C_AUTO_REWRITE 6'h0C
`define PEGR_C_PAGE_ERASE 6'h0D
`define PEGR_C_BLOCK_ERASE 6'h0E
`define PEGR_C_SECTOR_ERASE 6'h0F
`define PEGR_C_CHIP_ERASE 6'h10
`define PEGR_C_PROT_ENABLE 6'h11
`define PEGR_C_PROT_DISABLE 6'h12
`define PEGR_C_PROT_REG_ERASE 6'h13
`define PEGR_C_PROT_REG_PGM 6'h14
`define PEGR_C_PROT_REG_READ 6'h15
`define PEGR_C_LOCKDOWN 6'h16
`define PEGR_C_LOCK_READ 6'h17
`define PEGR_C_LOCK_FREEZE 6'h18
`define PEGR_C_SEC_REG_PGM 6'h19
`define PEGR_C_SEC_REG_READ 6'h1A
`define PEGR_C_XFER_BUF1 6'h1B
`define PEGR_C_XFER_BUF2 6'h1C
`define PEGR_C_CMP_BUF1 6'h1D
`define PEGR_C_CMP_BUF2 6'h1E
`define PEGR_C_DPD_ENTER 6'h1F
`define PEGR_C_DPD_EXIT 6'h20
`define PEGR_C_UDPD_ENTER 6'h21
`define PEGR_C_CFG_READ 6'h22
`define PEGR_C_STATUS_READ 6'h23
`define PEGR_C_ID_READ 6'h24
`define PEGR_C_SW_RESET 6'h25

`endif

// ---- rtl/pegr_gate.v ----
// suspend/resume sequencer and command gate of the serial flash
// assumes: decoder pulses cmd_done at chip-select release, same clock;
// the array engine reports starts and completions of program/erase
//
// What this block does
// (R1) resume is opcode D0h alone; trailing data ignored; acts at chip-select release
// (R2) resume clears the matching suspend flag and reports busy again
// (R3) program and erase both suspended: resume restarts program, next resume erase
// (R4) suspend requests arriving while a resume is in progress are ignored
// (R5) host waits resume latency or polls flags before suspending again
// (R6) array and both buffer reads accepted in every suspend state
// (R7) buffer write/transfer/compare refused only for buffer holding suspended program
// (R8) buffer-to-memory program without erase accepted only during erase suspend
// (R9) memory program through buffer one without erase only during erase suspend
// (R10) erase-type programs, auto rewrite and all erases refused in any suspend
// (R11) protection, lockdown and security register changes refused in any suspend
// (R12) protection, lockdown and security register reads accepted in any suspend
// (R13) deep and ultra-deep power-down entry and exit refused in any suspend
// (R14) config, status, id reads and resets accepted in any suspend
// (R15) suspend is opcode B0h; sets matching suspend flag, reports ready
// (R16) refused command is discarded with no state change anywhere
`include "pegr_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module pegr_gate (
  input wire clock,
  input wire srst,
  input wire cmd_done,
  input wire [7:0] cmd_opcode,
  input wire [`PEGR_CLS_W-1:0] cmd_class,
  input wire op_start_prog,
  input wire op_start_buf_two,
  input wire op_start_erase,
  input wire op_done,
  output reg cmd_accept_reg,
  output reg cmd_reject_reg,
  output reg eng_suspend_reg,
  output reg eng_resume_prog_reg,
  output reg eng_resume_erase_reg,
  output reg prog_suspended_buf_one,
  output reg prog_suspended_buf_two,
  output reg erase_suspended_flag,
  output reg busy_reg,
  output reg resuming_reg
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SUSP = 3'b010;
  localparam [2:0] ST_RES = 3'b100;
  // counts worked out as integers, then cut to the counter width on purpose
  localparam integer SUSP_CYC_INT = `PEGR_SUSPEND_CYC;
  localparam integer RES_CYC_INT = `PEGR_RESUME_CYC;
  localparam [`PEGR_CNT_W-1:0] SUSP_CYC = SUSP_CYC_INT[`PEGR_CNT_W-1:0];
  localparam [`PEGR_CNT_W-1:0] RES_CYC = RES_CYC_INT[`PEGR_CNT_W-1:0];
  localparam [`PEGR_CNT_W-1:0] CNT_LAST = {{(`PEGR_CNT_W-1){1'b0}}, 1'b1};

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`PEGR_CNT_W-1:0] cnt_reg;
  reg [`PEGR_CNT_W-1:0] cnt_next;
  reg run_prog_reg;
  reg run_prog_next;
  reg run_buf_two_reg;
  reg run_buf_two_next;
  reg run_erase_reg;
  reg run_erase_next;
  reg ps1_next;
  reg ps2_next;
  reg es_next;
  reg accept_next;
  reg reject_next;
  reg susp_pulse_next;
  reg res_prog_next;
  reg res_erase_next;

  // gate decision for one command class in the present suspend state
  function allowed;
    input [`PEGR_CLS_W-1:0] cls;
    input p1;
    input p2;
    input e;
    reg any;
    begin
      any = p1 | p2 | e;
      case (cls)
        `PEGR_C_READ_ARRAY, `PEGR_C_READ_BUF1, `PEGR_C_READ_BUF2:
          allowed = 1'b1; // R6
        `PEGR_C_BUF1_WRITE, `PEGR_C_XFER_BUF1, `PEGR_C_CMP_BUF1:
          allowed = ~p1; // R7
        `PEGR_C_BUF2_WRITE, `PEGR_C_XFER_BUF2, `PEGR_C_CMP_BUF2:
          allowed = ~p2; // R7
        `PEGR_C_B1_PGM_NOERASE, `PEGR_C_B2_PGM_NOERASE:
          allowed = e & ~p1 & ~p2; // R8
        `PEGR_C_MP_B1_NOERASE:
          allowed = e & ~p1 & ~p2; // R9
        `PEGR_C_B1_PGM_ERASE, `PEGR_C_B2_PGM_ERASE, `PEGR_C_MP_B1_ERASE,
        `PEGR_C_MP_B2_ERASE, `PEGR_C_AUTO_REWRITE, `PEGR_C_PAGE_ERASE,
        `PEGR_C_BLOCK_ERASE, `PEGR_C_SECTOR_ERASE, `PEGR_C_CHIP_ERASE:
          allowed = ~any; // R10
        `PEGR_C_PROT_ENABLE, `PEGR_C_PROT_DISABLE, `PEGR_C_PROT_REG_ERASE,
        `PEGR_C_PROT_REG_PGM, `PEGR_C_LOCKDOWN, `PEGR_C_LOCK_FREEZE,
        `PEGR_C_SEC_REG_PGM:
          allowed = ~any; // R11
        `PEGR_C_PROT_REG_READ, `PEGR_C_LOCK_READ, `PEGR_C_SEC_REG_READ:
          allowed = 1'b1; // R12
        `PEGR_C_DPD_ENTER, `PEGR_C_DPD_EXIT, `PEGR_C_UDPD_ENTER:
          allowed = ~any; // R13
        `PEGR_C_CFG_READ, `PEGR_C_STATUS_READ, `PEGR_C_ID_READ,
        `PEGR_C_SW_RESET:
          allowed = 1'b1; // R14
        default:
          allowed = ~any; // unknown classes are refused while anything is suspended
      endcase
    end
  endfunction

  wire is_suspend = cmd_done & (cmd_opcode == `PEGR_OP_SUSPEND);
  wire is_resume = cmd_done & (cmd_opcode == `PEGR_OP_RESUME);
  wire is_other = cmd_done & ~is_suspend & ~is_resume;
  wire any_susp = prog_suspended_buf_one | prog_suspended_buf_two | erase_suspended_flag;
  wire other_ok = allowed(cmd_class, prog_suspended_buf_one, prog_suspended_buf_two,
    erase_suspended_flag);

  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    run_prog_next = run_prog_reg;
    run_buf_two_next = run_buf_two_reg;
    run_erase_next = run_erase_reg;
    ps1_next = prog_suspended_buf_one;
    ps2_next = prog_suspended_buf_two;
    es_next = erase_suspended_flag;
    accept_next = 1'b0;
    reject_next = 1'b0;
    susp_pulse_next = 1'b0;
    res_prog_next = 1'b0;
    res_erase_next = 1'b0;

    // engine reports; at most one operation runs at a time
    if (op_done)
    begin
      run_prog_next = 1'b0;
      run_erase_next = 1'b0;
    end
    if (op_start_prog)
    begin
      run_prog_next = 1'b1;
      run_buf_two_next = op_start_buf_two;
    end
    if (op_start_erase)
      run_erase_next = 1'b1;

    case (state_reg)
      ST_IDLE:
      begin
        if (is_suspend)
        begin
          // nothing running: a stray suspend has no effect
          if (run_prog_reg | run_erase_reg)
          begin
            state_next = ST_SUSP;
            cnt_next = SUSP_CYC;
            susp_pulse_next = 1'b1;
            accept_next = 1'b1;
          end
          else
            reject_next = 1'b1;
        end
        else if (is_resume)
        begin
          if (prog_suspended_buf_one | prog_suspended_buf_two)
          begin
            ps1_next = 1'b0; // R2
            ps2_next = 1'b0; // R2
            run_prog_next = 1'b1; // R3
            res_prog_next = 1'b1; // R1
            state_next = ST_RES;
            cnt_next = RES_CYC;
            accept_next = 1'b1;
          end
          else if (erase_suspended_flag & ~run_prog_reg) // R3
          begin
            es_next = 1'b0; // R2
            run_erase_next = 1'b1;
            res_erase_next = 1'b1; // R1
            state_next = ST_RES;
            cnt_next = RES_CYC;
            accept_next = 1'b1;
          end
          else
            reject_next = 1'b1;
        end
        else if (is_other)
        begin
          if (other_ok)
          begin
            accept_next = 1'b1;
            // an accepted reset in ST_IDLE aborts every suspended operation; one accepted in ST_RES aborts nothing
            if (cmd_class == `PEGR_C_SW_RESET)
            begin
              ps1_next = 1'b0;
              ps2_next = 1'b0;
              es_next = 1'b0;
              run_prog_next = 1'b0;
              run_erase_next = 1'b0;
            end
          end
          else
            reject_next = 1'b1; // R16
        end
      end
      ST_SUSP:
      begin
        // the decoder is expected to hold off commands until ready
        if (cmd_done)
          reject_next = 1'b1;
        if (cnt_reg <= CNT_LAST)
        begin
          state_next = ST_IDLE;
          cnt_next = {`PEGR_CNT_W{1'b0}};
          if (run_prog_reg)
          begin
            ps1_next = ~run_buf_two_reg; // R15
            ps2_next = run_buf_two_reg; // R15
            run_prog_next = 1'b0;
          end
          else
          begin
            es_next = 1'b1; // R15
            run_erase_next = 1'b0;
          end
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_RES:
      begin
        if (is_suspend)
          reject_next = 1'b1; // R4
        else if (is_resume)
          reject_next = 1'b1; // R3
        // erase flag may still be set while the program resumes
        else if (is_other & ~other_ok)
          reject_next = 1'b1; // R16
        else if (cmd_done)
          accept_next = 1'b1;
        if (cnt_reg <= CNT_LAST)
        begin
          state_next = ST_IDLE;
          cnt_next = {`PEGR_CNT_W{1'b0}};
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      default:
      begin
        state_next = ST_IDLE;
        cnt_next = {`PEGR_CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= {`PEGR_CNT_W{1'b0}};
      run_prog_reg <= 1'b0;
      run_buf_two_reg <= 1'b0;
      run_erase_reg <= 1'b0;
      prog_suspended_buf_one <= 1'b0;
      prog_suspended_buf_two <= 1'b0;
      erase_suspended_flag <= 1'b0;
      cmd_accept_reg <= 1'b0;
      cmd_reject_reg <= 1'b0;
      eng_suspend_reg <= 1'b0;
      eng_resume_prog_reg <= 1'b0;
      eng_resume_erase_reg <= 1'b0;
      busy_reg <= 1'b0;
      resuming_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      run_prog_reg <= run_prog_next;
      run_buf_two_reg <= run_buf_two_next;
      run_erase_reg <= run_erase_next;
      prog_suspended_buf_one <= ps1_next;
      prog_suspended_buf_two <= ps2_next;
      erase_suspended_flag <= es_next;
      cmd_accept_reg <= accept_next;
      cmd_reject_reg <= reject_next;
      eng_suspend_reg <= susp_pulse_next;
      eng_resume_prog_reg <= res_prog_next;
      eng_resume_erase_reg <= res_erase_next;
      // busy while an operation runs or a suspend is still settling
      busy_reg <= run_prog_next | run_erase_next | (state_next == ST_SUSP); // R2
      resuming_reg <= (state_next == ST_RES);
    end
  end

endmodule // pegr_gate

`default_nettype wire

// ---- verification/pegr_gate_properties.sv ----
// concurrent checks on the ports of the suspend/resume command gate
// assumes one clock domain and the synchronous srst of the gate
`include "pegr_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module pegr_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_done,
  input wire logic [7:0] cmd_opcode,
  input wire logic [`PEGR_CLS_W-1:0] cmd_class,
  input wire logic cmd_accept_reg,
  input wire logic cmd_reject_reg,
  input wire logic eng_suspend_reg,
  input wire logic eng_resume_prog_reg,
  input wire logic eng_resume_erase_reg,
  input wire logic prog_suspended_buf_one,
  input wire logic prog_suspended_buf_two,
  input wire logic erase_suspended_flag,
  input wire logic busy_reg,
  input wire logic resuming_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire logic ps = prog_suspended_buf_one | prog_suspended_buf_two;
  wire logic flg = ps | erase_suspended_flag;
  wire logic rsm = cmd_done && cmd_opcode == `PEGR_OP_RESUME;
  wire logic sus = cmd_done && cmd_opcode == `PEGR_OP_SUSPEND;
  // settled suspend only: table does not apply while busy
  wire logic plain = cmd_done && !rsm && !sus && flg && !busy_reg;
  a_one_answer: assert property (cmd_done |=> cmd_accept_reg ^ cmd_reject_reg)
    else $error("command not answered exactly once");
  a_resume_prog_first: assert property (rsm && ps |=> !ps && busy_reg && eng_resume_prog_reg
    && erase_suspended_flag == $past(erase_suspended_flag)) else $error("program resume wrong");
  a_resume_erase: assert property (rsm && !ps && erase_suspended_flag && !busy_reg
    |=> !erase_suspended_flag && busy_reg && eng_resume_erase_reg) else $error("erase resume wrong");
  a_suspend_ignored: assert property (sus && resuming_reg |=> cmd_reject_reg && !eng_suspend_reg)
    else $error("suspend taken while resuming");
  a_chip_erase_refused: assert property (plain && cmd_class == 6'h10 |=> cmd_reject_reg)
    else $error("erase allowed in suspend");
  a_array_read_ok: assert property (plain && cmd_class <= 6'h02 |=> cmd_accept_reg)
    else $error("read refused in suspend");
  a_same_buf_refused: assert property (plain && prog_suspended_buf_one && cmd_class == 6'h03
    |=> cmd_reject_reg) else $error("write to suspended buffer allowed");
  a_noerase_in_es: assert property (plain && !ps && cmd_class == 6'h07 |=> cmd_accept_reg)
    else $error("program without erase refused in erase suspend");
  a_reject_quiet: assert property (cmd_reject_reg && !$past(busy_reg) |-> !eng_suspend_reg
    && $stable({ps, erase_suspended_flag, busy_reg})) else $error("refused command changed state");
  c_both_resume: cover property (rsm && ps && erase_suspended_flag);
  c_susp_resuming: cover property (sus && resuming_reg);
  c_settled: cover property ($fell(busy_reg) && flg);
endmodule // pegr_chk
bind pegr_gate pegr_chk chk (
  .clock(clock),
  .srst(srst),
  .cmd_done(cmd_done),
  .cmd_opcode(cmd_opcode),
  .cmd_class(cmd_class),
  .cmd_accept_reg(cmd_accept_reg),
  .cmd_reject_reg(cmd_reject_reg),
  .eng_suspend_reg(eng_suspend_reg),
  .eng_resume_prog_reg(eng_resume_prog_reg),
  .eng_resume_erase_reg(eng_resume_erase_reg),
  .prog_suspended_buf_one(prog_suspended_buf_one),
  .prog_suspended_buf_two(prog_suspended_buf_two),
  .erase_suspended_flag(erase_suspended_flag),
  .busy_reg(busy_reg),
  .resuming_reg(resuming_reg)
);
`default_nettype wire

// ---- verification/pegr_host.sv ----
// host-side model: issues one flash command per chip-select frame
// assumes the gate samples cmd_done on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module pegr_host (
  input wire logic clock,
  output logic cmd_done,
  output logic [7:0] cmd_opcode,
  output logic [5:0] cmd_class
);
  initial
  begin
    cmd_done = 1'b0;
    cmd_opcode = 8'h00;
    cmd_class = 6'h00;
  end
  task send(input logic [7:0] op, input logic [5:0] c);
    // random idle gap; every drive lands right on a rising edge
    repeat (1 + $urandom % 3) @(posedge clock);
    cmd_done <= 1'b1;
    cmd_opcode <= op;
    cmd_class <= c;
    @(posedge clock);
    cmd_done <= 1'b0;
    // released bus must not keep showing the last command
    cmd_opcode <= ~op;
    cmd_class <= ~c;
  endtask
endmodule // pegr_host
`default_nettype wire

// ---- verification/pegr_gate_test.sv ----
// self-checking bench for the suspend/resume gate against a queue-free model
// assumes host model, checker bind and the gate header constants
`include "pegr_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module pegr_gate_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic op_start_prog = 1'b0;
  logic op_start_buf_two = 1'b0;
  logic op_start_erase = 1'b0;
  logic op_done = 1'b0;
  wire logic cmd_done, cmd_accept_reg, cmd_reject_reg, eng_suspend_reg;
  wire logic eng_resume_prog_reg, eng_resume_erase_reg, busy_reg, resuming_reg;
  wire logic prog_suspended_buf_one, prog_suspended_buf_two, erase_suspended_flag;
  wire logic [7:0] cmd_opcode;
  wire logic [`PEGR_CLS_W-1:0] cmd_class;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  int m1 = 0, m2 = 0, me = 0, mb = 0, mk = 0, mres = 0;
  always #25 clock = ~clock;
  pegr_gate dut (
    .clock(clock),
    .srst(srst),
    .cmd_done(cmd_done),
    .cmd_opcode(cmd_opcode),
    .cmd_class(cmd_class),
    .op_start_prog(op_start_prog),
    .op_start_buf_two(op_start_buf_two),
    .op_start_erase(op_start_erase),
    .op_done(op_done),
    .cmd_accept_reg(cmd_accept_reg),
    .cmd_reject_reg(cmd_reject_reg),
    .eng_suspend_reg(eng_suspend_reg),
    .eng_resume_prog_reg(eng_resume_prog_reg),
    .eng_resume_erase_reg(eng_resume_erase_reg),
    .prog_suspended_buf_one(prog_suspended_buf_one),
    .prog_suspended_buf_two(prog_suspended_buf_two),
    .erase_suspended_flag(erase_suspended_flag),
    .busy_reg(busy_reg),
    .resuming_reg(resuming_reg)
  );
  pegr_host host (
    .clock(clock),
    .cmd_done(cmd_done),
    .cmd_opcode(cmd_opcode),
    .cmd_class(cmd_class)
  );
  task test_done;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      test_done;
    end
  end
  task chk(input string n, input logic [8:0] s, input logic [8:0] e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  function int allow(input logic [5:0] c);
    if (!(m1 | m2 | me))
      return 1;
    case (c)
      6'h00, 6'h01, 6'h02, 6'h15, 6'h17, 6'h1A, 6'h22, 6'h23, 6'h24, 6'h25: return 1;
      6'h03, 6'h1B, 6'h1D: return !m1;
      6'h04, 6'h1C, 6'h1E: return !m2;
      6'h07, 6'h08, 6'h0B: return me && !m1 && !m2;
      default: return 0;
    endcase
  endfunction
  task cmd(input logic [7:0] op, input logic [5:0] c);
    int a, rp, re, sp;
    logic [8:0] seen;
    a = 0;
    rp = 0;
    re = 0;
    if (op == `PEGR_OP_SUSPEND)
      a = mb && !mres;
    else if (op == `PEGR_OP_RESUME)
    begin
      rp = m1 | m2;
      re = me && !rp && !mb;
      a = rp | re;
      m1 = 0;
      m2 = 0;
      me = me && !re;
      mb = mb | a;
      mres = mres | a;
    end
    else
      a = allow(c);
    if (a && op != `PEGR_OP_SUSPEND && op != `PEGR_OP_RESUME && c == 6'h25)
    begin
      {m1, m2, me, mb, mres} = '0;
    end
    sp = a && op == `PEGR_OP_SUSPEND;
    host.send(op, c);
    #1;
    seen = {cmd_accept_reg, cmd_reject_reg, eng_suspend_reg, eng_resume_prog_reg,
      eng_resume_erase_reg, prog_suspended_buf_one, prog_suspended_buf_two, erase_suspended_flag,
      busy_reg};
    chk("answer", seen, {a[0], !a, sp[0], rp[0], re[0], m1[0], m2[0], me[0], mb[0]});
    chk("resuming", {8'h00, resuming_reg}, {8'h00, mres[0]});
  endtask
  task ev(input logic p, input logic b2, input logic e, input logic d);
    @(posedge clock);
    op_start_prog <= p;
    op_start_buf_two <= b2;
    op_start_erase <= e;
    op_done <= d;
    @(posedge clock);
    {op_start_prog, op_start_erase, op_done} <= 3'b000;
    if (p | e)
      mk = e ? 3 : b2 ? 2 : 1;
    mb = (mb | p | e) & !d;
    #1;
    chk("busy", {8'h00, busy_reg}, {8'h00, mb[0]});
  endtask
  task susp;
    int n;
    logic [8:0] seen;
    n = 0;
    cmd(`PEGR_OP_SUSPEND, 6'h00);
    while (busy_reg !== 1'b0 && n < 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    mb = 0;
    m1 = m1 | mk == 1;
    m2 = m2 | mk == 2;
    me = me | mk == 3;
    seen = {6'h00, prog_suspended_buf_one, prog_suspended_buf_two, erase_suspended_flag};
    chk("flags", seen, {6'h00, m1[0], m2[0], me[0]});
  endtask
  task wres;
    int n;
    n = 0;
    // host polls before suspending again
    while (resuming_reg !== 1'b0 && n < 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    mres = 0;
    chk("resume window", {8'h00, resuming_reg}, 9'h000);
  endtask
  task sweep;
    for (int c = 0; c < 40; c++)
      if (c != 37)
        cmd(8'($urandom & 32'h7F), c[5:0]);
  endtask
  initial
  begin
    void'($urandom(32'h5599_3534));
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    cmd(`PEGR_OP_SUSPEND, 6'h00);
    cmd(`PEGR_OP_RESUME, 6'h00);
    cmd(8'h12, 6'h10);
    ev(1'b0, 1'b0, 1'b1, 1'b0);
    susp;
    sweep;
    ev(1'b1, 1'b0, 1'b0, 1'b0);
    susp;
    sweep;
    cmd(`PEGR_OP_RESUME, 6'h00);
    cmd(`PEGR_OP_SUSPEND, 6'h00);
    cmd(`PEGR_OP_RESUME, 6'h00);
    wres;
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    cmd(`PEGR_OP_RESUME, 6'h00);
    wres;
    ev(1'b0, 1'b0, 1'b0, 1'b1);
    ev(1'b1, 1'b1, 1'b0, 1'b0);
    susp;
    sweep;
    cmd(8'h01, 6'h25);
    test_done;
  end
endmodule // pegr_gate_test
`default_nettype wire
